/* rtl/sad_decoder.v */
// system address decoder: region steering, window translation, access filter
`timescale 1ns/100ps
`include "sad_defines.vh"

// How it works
// - every resource sits in one flat 4 Gbyte space of 32-bit addresses
// - up to four sdram banks, each 16M to 128M, total at most 512M
// - sdram banks packed back to back into one contiguous range
// - gap between last sdram bank end and 0x2000_0000 is reserved
// - four async banks each own a fixed 64 Mbyte segment
// - fixed 128 Mbyte window onto bus memory, base register relocates it
// - fixed 64K window onto bus I/O space, base register relocates it
// - one-value configuration window carries target address and write data
// - control registers near top split into core block and system block
// - core control block only for core in supervisor, else reserved
// - system control block for supervisor core, others per protection setting
// - scratch pad is data only, never cache, never reached by dma
// - 16K instruction region works as 4-way cache or plain memory
// - each 16K data bank is plain memory or one way of 2-way cache
// - 256K unified L2 reached by core over a 64-bit port
module sad_decoder #(
  parameter BANKS = 4
) (
  input  wire        SYS_CLK_I,
  input  wire        RST_I,
  input  wire        CE_I,
  input  wire        REQ_VALID_I,
  input  wire [31:0] REQ_ADDR_I,
  input  wire        REQ_WRITE_I,
  input  wire        REQ_IFETCH_I,
  input  wire [1:0]  REQ_MASTER_I,
  input  wire        REQ_SUPER_I,
  input  wire [31:0] SDRAM_SIZES_I,
  input  wire [4:0]  PCI_MEM_BASE_I,
  input  wire [15:0] PCI_IO_BASE_I,
  input  wire        SYS_CTRL_OPEN_I,
  input  wire        L1_INST_CACHE_I,
  input  wire        L1_DA_CACHE_I,
  input  wire        L1_DB_CACHE_I,
  output reg         FWD_VALID_O,
  output reg  [10:0] FWD_REGION_O,
  output reg  [31:0] FWD_ADDR_O,
  output reg  [1:0]  FWD_BANK_O,
  output reg         FWD_WIDE_O,
  output reg         FWD_CFG_O,
  output reg         ERR_O
);

  // ---------------------------------------------------------------------
  // sdram bank limits
  // ---------------------------------------------------------------------
  // sizes in 16 Mbyte units, 8 bits per bank; a zero size is an empty bank
  reg  [7:0]  bank_end [0:BANKS];
  reg  [7:0]  bank_sz;
  integer     b;

  always @* begin
    bank_end[0] = 8'h00;
    bank_sz     = 8'h00;
    for (b = 0; b < BANKS; b = b + 1) begin
      bank_sz = SDRAM_SIZES_I[b*8 +: 8];
      // out of range sizes count as empty so total cannot pass 512M
      if (bank_sz > `SAD_SDRAM_MAX)
        bank_sz = 8'h00;
      bank_end[b+1] = bank_end[b] + bank_sz;
    end
  end

  wire [7:0] sdram_unit  = REQ_ADDR_I[31:`SAD_SDRAM_UNIT_LSB];
  wire [7:0] sdram_top   = (bank_end[BANKS] > `SAD_SDRAM_TOTAL) ?
                           `SAD_SDRAM_TOTAL : bank_end[BANKS];
  wire       in_sdram    = (sdram_unit < sdram_top);

  reg  [1:0] sdram_bank;
  reg  [31:0] sdram_off;
  integer    k;

  always @* begin
    sdram_bank = 2'h0;
    sdram_off  = REQ_ADDR_I;
    for (k = BANKS - 1; k >= 0; k = k - 1) begin
      if (sdram_unit < bank_end[k+1]) begin
        sdram_bank = k[1:0];
        sdram_off  = REQ_ADDR_I - {bank_end[k], 24'h00_0000};
      end
    end
  end

  // ---------------------------------------------------------------------
  // region match
  // ---------------------------------------------------------------------
  wire in_async  = (REQ_ADDR_I >= `SAD_ASYNC_BASE) &&
                   (REQ_ADDR_I < `SAD_ASYNC_END);
  wire in_pmem;
  wire in_pio;
  wire in_pcfg;
  wire in_l2;
  wire in_l1i;
  wire in_l1a;
  wire in_l1b;
  wire in_scr;
  wire in_sysc;
  wire in_corec;

  // fixed windows; overlap priority lives in the decode chain below
  sad_window #(
    .BASE (`SAD_PCI_MEM_BASE),
    .MASK (`SAD_PCI_MEM_MASK)
  ) u_pmem (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_pmem)
  );

  sad_window #(
    .BASE (`SAD_PCI_IO_BASE),
    .MASK (`SAD_PCI_IO_MASK)
  ) u_pio (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_pio)
  );

  // low two address bits are byte lanes of the single config word
  sad_window #(
    .BASE (`SAD_PCI_CFG_ADDR),
    .MASK (`SAD_PCI_CFG_MASK)
  ) u_pcfg (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_pcfg)
  );

  sad_window #(
    .BASE (`SAD_L2_BASE),
    .MASK (`SAD_L2_MASK)
  ) u_l2 (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_l2)
  );

  // each 16K bank has its own compare so cache modes stay independent
  sad_window #(
    .BASE (`SAD_L1_INST_BASE),
    .MASK (`SAD_L1_MASK)
  ) u_l1i (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_l1i)
  );

  sad_window #(
    .BASE (`SAD_L1_DA_BASE),
    .MASK (`SAD_L1_MASK)
  ) u_l1a (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_l1a)
  );

  sad_window #(
    .BASE (`SAD_L1_DB_BASE),
    .MASK (`SAD_L1_MASK)
  ) u_l1b (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_l1b)
  );

  sad_window #(
    .BASE (`SAD_SCRATCH_BASE),
    .MASK (`SAD_SCRATCH_MASK)
  ) u_scr (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_scr)
  );

  // core and system blocks each span 2 Mbyte near the top
  sad_window #(
    .BASE (`SAD_SYS_CTRL_BASE),
    .MASK (`SAD_CTRL_MASK)
  ) u_sysc (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_sysc)
  );

  sad_window #(
    .BASE (`SAD_CORE_CTRL_BASE),
    .MASK (`SAD_CTRL_MASK)
  ) u_corec (
    .addr_i (REQ_ADDR_I),
    .hit_o  (in_corec)
  );

  wire is_core   = (REQ_MASTER_I == `SAD_MST_CORE);
  wire is_dma    = (REQ_MASTER_I == `SAD_MST_DMA);
  wire core_sup  = is_core && REQ_SUPER_I;

  // ---------------------------------------------------------------------
  // decode and filter
  // ---------------------------------------------------------------------
  reg  [10:0] region_nxt;
  reg  [31:0] addr_nxt;
  reg  [1:0]  bank_nxt;
  reg         wide_nxt;
  reg         deny_nxt;

  always @* begin
    region_nxt = `SAD_RGN_NONE;
    addr_nxt   = REQ_ADDR_I;
    bank_nxt   = 2'h0;
    wide_nxt   = 1'h0;
    deny_nxt   = 1'h0;
    if (in_sdram) begin
      region_nxt = `SAD_RGN_SDRAM;
      addr_nxt   = sdram_off;
      bank_nxt   = sdram_bank;
    end else if (in_async) begin
      region_nxt = `SAD_RGN_ASYNC;
      bank_nxt   = REQ_ADDR_I[`SAD_ASYNC_SEG_LSB +: 2];
      addr_nxt   = {6'h00, REQ_ADDR_I[25:0]};
    end else if (in_pmem) begin
      region_nxt = `SAD_RGN_PCI_MEM;
      addr_nxt   = {PCI_MEM_BASE_I, REQ_ADDR_I[26:0]};
    end else if (in_pio) begin
      region_nxt = `SAD_RGN_PCI_IO;
      addr_nxt   = {PCI_IO_BASE_I, REQ_ADDR_I[15:0]};
    end else if (in_pcfg) begin
      // target address and data travel as payload of the window access
      region_nxt = `SAD_RGN_PCI_CFG;
    end else if (in_l2) begin
      region_nxt = `SAD_RGN_L2;
      addr_nxt   = {14'h0000, REQ_ADDR_I[17:0]};
      wide_nxt   = is_core;
    end else if (in_l1i) begin
      // cached instruction region has no direct address
      region_nxt = `SAD_RGN_L1_INST;
      addr_nxt   = {18'h0_0000, REQ_ADDR_I[13:0]};
      deny_nxt   = L1_INST_CACHE_I;
    end else if (in_l1a) begin
      region_nxt = `SAD_RGN_L1_DATA_A;
      addr_nxt   = {18'h0_0000, REQ_ADDR_I[13:0]};
      deny_nxt   = L1_DA_CACHE_I;
    end else if (in_l1b) begin
      region_nxt = `SAD_RGN_L1_DATA_B;
      addr_nxt   = {18'h0_0000, REQ_ADDR_I[13:0]};
      deny_nxt   = L1_DB_CACHE_I;
    end else if (in_scr) begin
      region_nxt = `SAD_RGN_SCRATCH;
      addr_nxt   = {20'h0_0000, REQ_ADDR_I[11:0]};
      // data only: no fetch and no dma path
      deny_nxt   = is_dma || REQ_IFETCH_I;
    end else if (in_corec) begin
      region_nxt = `SAD_RGN_CTRL;
      deny_nxt   = !core_sup;
    end else if (in_sysc) begin
      region_nxt = `SAD_RGN_CTRL;
      deny_nxt   = is_core ? !REQ_SUPER_I : !SYS_CTRL_OPEN_I;
    end
    if (region_nxt == `SAD_RGN_NONE)
      deny_nxt = 1'h1;
  end

  // ---------------------------------------------------------------------
  // registered answer, one cycle after the request
  // ---------------------------------------------------------------------
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      FWD_VALID_O  <= 1'h0;
      FWD_REGION_O <= `SAD_RGN_NONE;
      FWD_ADDR_O   <= 32'h0000_0000;
      FWD_BANK_O   <= 2'h0;
      FWD_WIDE_O   <= 1'h0;
      FWD_CFG_O    <= 1'h0;
      ERR_O        <= 1'h0;
    end else if (CE_I) begin
      FWD_VALID_O  <= REQ_VALID_I && !deny_nxt;
      ERR_O        <= REQ_VALID_I && deny_nxt;
      if (REQ_VALID_I && !deny_nxt) begin
        FWD_REGION_O <= region_nxt;
        FWD_ADDR_O   <= addr_nxt;
        FWD_BANK_O   <= bank_nxt;
        FWD_WIDE_O   <= wide_nxt;
        FWD_CFG_O    <= (region_nxt == `SAD_RGN_PCI_CFG);
      end else begin
        FWD_REGION_O <= `SAD_RGN_NONE;
        FWD_ADDR_O   <= 32'h0000_0000;
        FWD_BANK_O   <= 2'h0;
        FWD_WIDE_O   <= 1'h0;
        FWD_CFG_O    <= 1'h0;
      end
    end
  end

endmodule

// ---------------------------------------------------------------------
// one fixed window: ones in the mask pick the bits compared to the base
// ---------------------------------------------------------------------
module sad_window #(
  parameter [31:0] BASE = 32'h0000_0000,
  parameter [31:0] MASK = 32'hFFFF_FFFF
) (
  input  wire [31:0] addr_i,
  output wire        hit_o
);

  // purely combinational; the decoder registers what it steers
  assign hit_o = ((addr_i & MASK) == BASE);

endmodule

/* rtl/sad_defines.vh */
// address map constants for the system address decoder
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH
// region codes, one-hot
`define SAD_RGN_W          11
`define SAD_RGN_NONE       11'h000
`define SAD_RGN_SDRAM      11'h001
`define SAD_RGN_ASYNC      11'h002
`define SAD_RGN_PCI_MEM    11'h004
`define SAD_RGN_PCI_IO     11'h008
`define SAD_RGN_PCI_CFG    11'h010
`define SAD_RGN_L2         11'h020
`define SAD_RGN_L1_INST    11'h040
`define SAD_RGN_L1_DATA_A  11'h080
`define SAD_RGN_L1_DATA_B  11'h100
`define SAD_RGN_SCRATCH    11'h200
`define SAD_RGN_CTRL       11'h400
// master codes
`define SAD_MST_CORE       2'h0
`define SAD_MST_DMA        2'h1
`define SAD_MST_PERIPH     2'h2
`define SAD_MST_PCI        2'h3
// sdram bank sizes in 16 Mbyte units, address bits 31:24
`define SAD_SDRAM_UNIT_LSB 24
`define SAD_SDRAM_MIN      8'h01
`define SAD_SDRAM_MAX      8'h08
`define SAD_SDRAM_TOTAL    8'h20
// fixed bases
`define SAD_ASYNC_BASE     32'h2000_0000
`define SAD_ASYNC_END      32'h3000_0000
`define SAD_ASYNC_SEG_LSB  26
`define SAD_PCI_MEM_BASE   32'hE000_0000
`define SAD_PCI_MEM_MASK   32'hF800_0000
`define SAD_PCI_IO_BASE    32'hEEFE_0000
`define SAD_PCI_IO_MASK    32'hFFFF_0000
`define SAD_PCI_CFG_ADDR   32'hEEFF_FFFC
`define SAD_PCI_CFG_MASK   32'hFFFF_FFFC
`define SAD_L2_BASE        32'hF000_0000
`define SAD_L2_MASK        32'hFFFC_0000
`define SAD_L1_INST_BASE   32'hFFA0_0000
`define SAD_L1_DA_BASE     32'hFF80_0000
`define SAD_L1_DB_BASE     32'hFF90_0000
`define SAD_L1_MASK        32'hFFFF_C000
`define SAD_SCRATCH_BASE   32'hFFB0_0000
`define SAD_SCRATCH_MASK   32'hFFFF_F000
`define SAD_SYS_CTRL_BASE  32'hFFC0_0000
`define SAD_CORE_CTRL_BASE 32'hFFE0_0000
`define SAD_CTRL_MASK      32'hFFE0_0000
`endif

/* tb/sad_checker.sv */
// port assertions for the system address decoder
`timescale 1ns/100ps
`include "sad_defines.vh"
module sad_checker (
  input wire        SYS_CLK_I,
  input wire        RST_I,
  input wire        CE_I,
  input wire        REQ_VALID_I,
  input wire [31:0] REQ_ADDR_I,
  input wire        REQ_IFETCH_I,
  input wire [1:0]  REQ_MASTER_I,
  input wire        REQ_SUPER_I,
  input wire [31:0] SDRAM_SIZES_I,
  input wire        SYS_CTRL_OPEN_I,
  input wire        FWD_VALID_O,
  input wire [10:0] FWD_REGION_O,
  input wire        FWD_WIDE_O,
  input wire        FWD_CFG_O,
  input wire        ERR_O
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  function [8:0] u(input [7:0] s);
    u = (s > 8'h08) ? 9'h000 : {1'h0, s};
  endfunction
  wire [8:0] top  = u(SDRAM_SIZES_I[7:0]) + u(SDRAM_SIZES_I[15:8]) +
                    u(SDRAM_SIZES_I[23:16]) + u(SDRAM_SIZES_I[31:24]);
  wire       cc   = REQ_ADDR_I[31:21] == 11'h7FF;
  wire       sc   = REQ_ADDR_I[31:21] == 11'h7FE;
  wire       core = REQ_MASTER_I == `SAD_MST_CORE;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_take; CE_I && REQ_VALID_I; endsequence
  property p_one; s_take |=> FWD_VALID_O != ERR_O; endproperty
  a_one: assert property (p_one) else $error("answer not exactly one");
  property p_quiet; CE_I && !REQ_VALID_I |=> !FWD_VALID_O && !ERR_O; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_gap; s_take ##0 (REQ_ADDR_I[31:29] == 3'h0 && {1'h0, REQ_ADDR_I[31:24]} >= top)
    |=> ERR_O; endproperty
  a_gap: assert property (p_gap) else $error("gap after sdram accepted");
  property p_async; s_take ##0 REQ_ADDR_I[31:28] == 4'h2
    |=> FWD_VALID_O && FWD_REGION_O == `SAD_RGN_ASYNC; endproperty
  a_async: assert property (p_async) else $error("async segment misrouted");
  property p_core; s_take ##0 cc && !(core && REQ_SUPER_I) |=> ERR_O; endproperty
  a_core: assert property (p_core) else $error("core block reached");
  property p_sys; s_take ##0 sc && (core ? !REQ_SUPER_I : !SYS_CTRL_OPEN_I) |=> ERR_O; endproperty
  a_sys: assert property (p_sys) else $error("system block reached");
  property p_scr; s_take ##0 REQ_ADDR_I[31:12] == 20'hF_FB00 &&
    (REQ_IFETCH_I || REQ_MASTER_I == `SAD_MST_DMA) |=> ERR_O; endproperty
  a_scr: assert property (p_scr) else $error("scratch pad misused");
  property p_cfg; s_take ##0 REQ_ADDR_I == `SAD_PCI_CFG_ADDR |=> FWD_CFG_O && FWD_VALID_O; endproperty
  a_cfg: assert property (p_cfg) else $error("config window missed");
  property p_wide; s_take ##0 core && REQ_ADDR_I[31:18] == 14'h3C00 |=> FWD_WIDE_O; endproperty
  a_wide: assert property (p_wide) else $error("wide port not used");
endmodule

/* tb/sad_master.sv */
// request source standing in for core, dma, peripheral and bus host
`timescale 1ns/100ps
module sad_master (
  input  wire        clk_i,
  output reg         valid_o = 1'h0,
  output reg  [31:0] addr_o = 32'h0000_0000,
  output reg  [1:0]  mst_o = 2'h0,
  output reg         super_o = 1'h0,
  output reg         ifetch_o = 1'h0
);
  // called at a falling edge, returns at the next falling edge with the answer settled
  task send(input [31:0] a, input [1:0] m, input s, input f);
    begin
      valid_o = 1'h1;
      addr_o = a;
      mst_o = m;
      super_o = s;
      ifetch_o = f;
      @(negedge clk_i);
    end
  endtask
  // released address flips so a stale value cannot pass for a live one
  task idle;
    begin
      valid_o = 1'h0;
      addr_o = ~addr_o;
      @(negedge clk_i);
    end
  endtask
endmodule

/* tb/test_system_address_decoder.sv */
// self-checking bench for the system address decoder
`timescale 1ns/100ps
`include "sad_defines.vh"
module test_system_address_decoder;
  // ----------------------------------------
  // stimulus, checks and verdict
  // ----------------------------------------
  reg         clk = 1'h0;
  reg         rst = 1'h1;
  reg         ce = 1'h1;
  reg         open = 1'h0;
  reg  [2:0]  cache = 3'h0;
  reg  [31:0] sizes = 32'h0802_0401;
  reg  [4:0]  mbase = 5'h15;
  reg  [15:0] iobase = 16'hBEEF;
  wire        v, su, fx, wide, cfg, err, v_o;
  wire [1:0]  m, bank;
  wire [10:0] rg;
  wire [31:0] a, fa;
  integer     n_fail = 0;
  integer     total_checks = 0;
  always #5 clk = ~clk;
  sad_master mst (.clk_i(clk), .valid_o(v), .addr_o(a), .mst_o(m), .super_o(su), .ifetch_o(fx));
  sad_decoder dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .REQ_VALID_I(v), .REQ_ADDR_I(a),
    .REQ_WRITE_I(a[2]), .REQ_IFETCH_I(fx), .REQ_MASTER_I(m), .REQ_SUPER_I(su),
    .SDRAM_SIZES_I(sizes), .PCI_MEM_BASE_I(mbase), .PCI_IO_BASE_I(iobase),
    .SYS_CTRL_OPEN_I(open), .L1_INST_CACHE_I(cache[0]), .L1_DA_CACHE_I(cache[1]),
    .L1_DB_CACHE_I(cache[2]), .FWD_VALID_O(v_o), .FWD_REGION_O(rg), .FWD_ADDR_O(fa),
    .FWD_BANK_O(bank), .FWD_WIDE_O(wide), .FWD_CFG_O(cfg), .ERR_O(err));
  task chk(input [31:0] e, input [31:0] g, input [8*6:1] nm);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rq(input [31:0] ad, input [1:0] ms, input s, input f, input [10:0] er);
    begin
      mst.send(ad, ms, s, f);
      chk(er, rg, "region");
      chk(er == 11'h000, err, "error");
      chk(er != 11'h000, v_o, "valid");
    end
  endtask
  task t_map;
    begin
      rq(32'h0100_0000, 0, 1, 0, `SAD_RGN_SDRAM); chk(1, bank, "bank"); chk(0, fa, "addr");
      rq(32'h06FF_FFFC, 1, 0, 0, `SAD_RGN_SDRAM); chk(32'h01FF_FFFC, fa, "addr");
      rq(32'h0EFF_FFFF, 0, 0, 0, `SAD_RGN_SDRAM); chk(3, bank, "bank");
      rq(32'h0F00_0000, 1, 0, 0, `SAD_RGN_NONE);
      rq(32'h2FFF_FFFC, 3, 0, 0, `SAD_RGN_ASYNC); chk(3, bank, "bank");
      chk(32'h03FF_FFFC, fa, "addr");
      rq(32'hE123_4568, 0, 1, 0, `SAD_RGN_PCI_MEM); chk(32'hA923_4568, fa, "addr");
      rq(32'hEEFE_1234, 0, 1, 0, `SAD_RGN_PCI_IO); chk(32'hBEEF_1234, fa, "addr");
      rq(`SAD_PCI_CFG_ADDR, 0, 1, 0, `SAD_RGN_PCI_CFG); chk(1, cfg, "cfg");
      rq(32'h4000_0000, 0, 1, 0, `SAD_RGN_NONE);
      mst.idle;
      chk(0, v_o, "valid");
    end
  endtask
  task t_ctrl;
    begin
      rq(32'hFFE0_0010, 0, 1, 0, `SAD_RGN_CTRL);
      rq(32'hFFE0_0010, 0, 0, 0, `SAD_RGN_NONE);
      rq(32'hFFE0_0010, 3, 1, 0, `SAD_RGN_NONE);
      rq(32'hFFC0_0010, 0, 1, 0, `SAD_RGN_CTRL);
      rq(32'hFFC0_0010, 2, 0, 0, `SAD_RGN_NONE);
      open = 1'h1;
      rq(32'hFFC0_0010, 3, 0, 0, `SAD_RGN_CTRL);
      rq(32'hFFC0_0010, 0, 0, 0, `SAD_RGN_NONE);
      mst.idle;
    end
  endtask
  task t_mem;
    begin
      rq(32'hFFB0_0FFC, 0, 0, 0, `SAD_RGN_SCRATCH);
      chk(32'h0000_0FFC, fa, "addr");
      rq(32'hFFB0_0000, 1, 0, 0, `SAD_RGN_NONE);
      rq(32'hFFB0_0000, 0, 1, 1, `SAD_RGN_NONE);
      rq(32'hFFA0_3FFC, 0, 1, 1, `SAD_RGN_L1_INST);
      cache = 3'h3;
      rq(32'hFFA0_0000, 0, 1, 1, `SAD_RGN_NONE);
      rq(32'hFF80_0000, 0, 1, 0, `SAD_RGN_NONE);
      rq(32'hFF90_3FFC, 0, 1, 0, `SAD_RGN_L1_DATA_B);
      chk(32'h0000_3FFC, fa, "addr");
      rq(32'hF003_FFF8, 0, 1, 0, `SAD_RGN_L2); chk(1, wide, "wide");
      chk(32'h0003_FFF8, fa, "addr");
      rq(32'hF000_0000, 1, 0, 0, `SAD_RGN_L2); chk(0, wide, "wide");
      ce = 1'h0;
      mst.send(32'h4000_0000, 0, 1, 0);
      chk(`SAD_RGN_L2, rg, "region");
      ce = 1'h1;
      mst.idle;
    end
  endtask
  // other bank sizes and window bases, then a reset in mid-run
  task t_cfg;
    begin
      sizes = 32'h0009_0800;
      mbase = 5'h1F;
      iobase = 16'h0001;
      rq(32'h0000_0000, 0, 1, 0, `SAD_RGN_SDRAM);
      chk(1, bank, "bank");
      rq(32'h07FF_FFFC, 1, 0, 0, `SAD_RGN_SDRAM);
      chk(32'h07FF_FFFC, fa, "addr");
      rq(32'h0800_0000, 0, 1, 0, `SAD_RGN_NONE);
      rq(32'hE7FF_FFFC, 2, 0, 0, `SAD_RGN_PCI_MEM);
      chk(32'hFFFF_FFFC, fa, "addr");
      rq(32'hEEFE_0010, 3, 0, 0, `SAD_RGN_PCI_IO);
      chk(32'h0001_0010, fa, "addr");
      rst = 1'h1;
      mst.send(32'h0000_0000, 0, 1, 0);
      chk(0, v_o, "valid");
      chk(0, rg, "region");
      rst = 1'h0;
      rq(32'hFFE0_0000, 0, 1, 0, `SAD_RGN_CTRL);
      mst.idle;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_map;
    t_ctrl;
    t_mem;
    t_cfg;
    stop_test;
  end
  // whole run is well under a hundred requests
  initial begin
    #5000;
    n_fail = n_fail + 1;
    stop_test;
  end
endmodule
bind sad_decoder sad_checker chk_i (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
  .REQ_VALID_I(REQ_VALID_I), .REQ_ADDR_I(REQ_ADDR_I), .REQ_IFETCH_I(REQ_IFETCH_I),
  .REQ_MASTER_I(REQ_MASTER_I), .REQ_SUPER_I(REQ_SUPER_I), .SDRAM_SIZES_I(SDRAM_SIZES_I),
  .SYS_CTRL_OPEN_I(SYS_CTRL_OPEN_I), .FWD_VALID_O(FWD_VALID_O), .FWD_REGION_O(FWD_REGION_O),
  .FWD_WIDE_O(FWD_WIDE_O), .FWD_CFG_O(FWD_CFG_O), .ERR_O(ERR_O));
